// *** verilog/rpc_pkg.sv ***
package rpc_pkg;
   // ------------------------------------------------------------
   // Register map (index; byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_CTRL = 8'h10;
   localparam logic [7:0] IDX_SUPP = 8'h11;
   localparam logic [7:0] IDX_DATA = 8'h18;
   localparam logic [7:0] IDX_STAT = 8'h19;
   localparam logic [7:0] CTRL_RESET_VAL = 8'h00;
   localparam logic [7:0] SUPP_RESET_VAL = 8'h00;
   localparam int CTRL_CRC_BIT = 7;
   localparam int CTRL_RST_BIT = 6;
   localparam int CTRL_SRC_BIT = 5;
   localparam int SLOT_W = 5;
   localparam int DATA_VALID_BIT = 8;
   localparam int DATA_EOP_BIT = 9;
   localparam int DATA_BAD_BIT = 10;
   localparam int STAT_EMPTY_BIT = 0;
   localparam int STAT_FULL_BIT = 1;
   localparam int STAT_OVF_BIT = 2;
   localparam int STAT_BUSY_BIT = 3;
   localparam int STAT_LVL_LSB = 8;
   // ------------------------------------------------------------
   // Packet framing constants
   // ------------------------------------------------------------
   localparam logic [7:0] FLAG_PAT = 8'h7E;
   localparam logic [6:0] ABORT_PAT = 7'h7F;
   localparam logic [2:0] STUFF_ONES = 3'h5;
   localparam logic [3:0] FLAG_SKIP = 4'h8;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam logic [15:0] CRC_GOOD = 16'hF0B8;
   localparam logic [1:0] EMIT_WITH_CRC = 2'h3;
   localparam logic [1:0] EMIT_NO_CRC = 2'h1;

   // One received line bit with its position in the frame
   typedef struct packed {
      logic frame_start;
      logic bit_en;
      logic bit_val;
      logic [4:0] slot;
      logic [2:0] bit_pos;
      logic ovh;
   } rpc_frame_s;

   // One octet on its way to the receive FIFO
   typedef struct packed {
      logic bad;
      logic eop;
      logic [7:0] data;
   } rpc_octet_s;

   // Bit-serial CRC-16, LSB first
   function automatic logic [15:0] rpc_crc_next(input logic [15:0] crc, input logic b);
      logic fb;
      fb = crc[0] ^ b;
      rpc_crc_next = (crc >> 1) ^ (fb ? CRC_POLY : 16'h0000);
   endfunction
endpackage

// *** verilog/rpc_fifo.sv ***
`timescale 1ns/10ps
module rpc_fifo
   import rpc_pkg::*;
#(
   parameter int WIDTH = 10,
   parameter int DEPTH = 64
) (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_flush,
   input wire logic i_push,
   input wire logic [WIDTH-1:0] i_data,
   input wire logic i_pop,
   output logic [WIDTH-1:0] o_data,
   output logic o_empty,
   output logic o_full,
   output logic [$clog2(DEPTH+1)-1:0] o_level
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int LVL_W = $clog2(DEPTH+1);

   if (DEPTH < 4 || DEPTH > 255 || (1 << PTR_W) != DEPTH) begin : g_chk
      $error("rpc_fifo: DEPTH must be a power of two from 4 to 128");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   wire do_push = i_push && !o_full;
   wire do_pop = i_pop && !o_empty;

   // ------------------------------------------------------------
   // Storage; a push into a full FIFO is dropped here
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (do_push) begin
         mem[wr_ptr] <= i_data;
      end
   end

   assign o_data = mem[rd_ptr];
   assign o_empty = (o_level == LVL_W'(0));
   assign o_full = (o_level == LVL_W'(DEPTH));

   // Pointers and fill level, flush wins over push and pop
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         o_level <= '0;
      end else if (i_flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         o_level <= '0;
      end else begin
         wr_ptr <= wr_ptr + PTR_W'(do_push);
         rd_ptr <= rd_ptr + PTR_W'(do_pop);
         o_level <= o_level + LVL_W'(do_push) - LVL_W'(do_pop);
      end
   end
endmodule

// *** verilog/rpc_receive_packet_control.sv ***
// Behaviour
// RULE1 - With crc_to_fifo_enable set the two received CRC octets follow the last packet octet in the FIFO; clear omits them.
// RULE2 - Setting receive_packet_soft_reset reinitialises the packet receiver and empties the receive FIFO.
// RULE3 - The soft reset bit is cleared by the device itself when the reset is done; software only writes one.
// RULE4 - The soft reset completes and its bit clears within two received frames of being set.
// RULE5 - packet_source_select clear takes data from a timeslot; set takes the data link or Sa bits.
// RULE6 - The five-bit packet_timeslot_select picks the timeslot, zero meaning channel 1 and all ones channel 32.
// RULE7 - A new packet_timeslot_select value is applied only by a following soft reset.
// RULE8 - Each set bit of receive_packet_bit_suppress removes that bit position of the timeslot from the packet data.
// RULE9 - Suppress bit 7 (suppress_msb) is timeslot bit 8, suppress bit 0 (suppress_lsb) is bit 1, in order between.
// RULE10 - During the soft reset incoming data and a partial packet are dropped and flag hunting restarts.
`timescale 1ns/10ps
module rpc_receive_packet_control
   import rpc_pkg::*;
#(
   parameter int FIFO_DEPTH = 64
) (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire rpc_frame_s i_rx,
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest
);
   localparam int LVL_W = $clog2(FIFO_DEPTH+1);
   localparam int OCT_W = $bits(rpc_octet_s);

   typedef enum logic [1:0] {
      ST_HUNT = 2'b01,
      ST_DATA = 2'b10
   } rpc_rx_state_e;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic crc_to_fifo_enable;
   logic receive_packet_soft_reset;
   logic packet_source_select;
   logic [SLOT_W-1:0] packet_timeslot_select;
   logic [SLOT_W-1:0] applied_slot;
   logic [7:0] receive_packet_bit_suppress;
   logic overflow;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire req = i_avs_read || i_avs_write;
   wire accept = req && !o_avs_waitrequest;
   wire [7:0] word_idx = i_avs_address[9:2];
   wire lane0 = i_avs_byteenable[0];
   wire hit_ctrl = (word_idx == IDX_CTRL);
   wire hit_supp = (word_idx == IDX_SUPP);
   wire hit_data = (word_idx == IDX_DATA);
   wire hit_stat = (word_idx == IDX_STAT);
   wire wr_ctrl = accept && i_avs_write && hit_ctrl && lane0;
   wire wr_supp = accept && i_avs_write && hit_supp && lane0;

   // FIFO side signals
   rpc_octet_s fifo_out;
   logic [OCT_W-1:0] fifo_rd_bits;
   logic fifo_empty;
   logic fifo_full;
   logic [LVL_W-1:0] fifo_level;
   logic push;
   rpc_octet_s push_oct;
   wire pop = accept && i_avs_read && hit_data;
   assign fifo_out = rpc_octet_s'(fifo_rd_bits);

   // Read data mux, unmapped words read as zero
   wire [31:0] rd_ctrl = {24'h000000, crc_to_fifo_enable, receive_packet_soft_reset,
                          packet_source_select, packet_timeslot_select};
   wire [31:0] rd_supp = {24'h000000, receive_packet_bit_suppress};
   wire [31:0] rd_data = fifo_empty ? 32'h00000000 :
                         {21'h000000, fifo_out.bad, fifo_out.eop, 1'b1, fifo_out.data};
   wire [31:0] rd_stat = {{(32-STAT_LVL_LSB-LVL_W){1'b0}}, fifo_level, 4'h0,
                          receive_packet_soft_reset, overflow, fifo_full, fifo_empty};
   wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                        hit_supp ? rd_supp :
                        hit_data ? rd_data :
                        hit_stat ? rd_stat : 32'h00000000;

   // ------------------------------------------------------------
   // Avalon slave: one wait cycle, then the transfer completes
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h00000000;
      end else begin
         o_avs_waitrequest <= !(req && o_avs_waitrequest);
         // Only a read reloads the data, so it stands across writes
         if (i_avs_read && o_avs_waitrequest) begin
            o_avs_readdata <= rd_mux;
         end
      end
   end

   // ------------------------------------------------------------
   // Soft reset sequencing
   // ------------------------------------------------------------
   // Completion waits for a frame boundary so the new slot starts clean
   wire reset_done = receive_packet_soft_reset && i_rx.frame_start;
   wire set_reset = wr_ctrl && i_avs_writedata[CTRL_RST_BIT];
   // RULE3 self clearing; a new set beats the clear
   wire next_soft_reset = set_reset || (receive_packet_soft_reset && !reset_done);

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         crc_to_fifo_enable <= CTRL_RESET_VAL[CTRL_CRC_BIT];
         receive_packet_soft_reset <= CTRL_RESET_VAL[CTRL_RST_BIT];
         packet_source_select <= CTRL_RESET_VAL[CTRL_SRC_BIT];
         packet_timeslot_select <= CTRL_RESET_VAL[SLOT_W-1:0];
         receive_packet_bit_suppress <= SUPP_RESET_VAL;
      end else begin
         // RULE4 cleared at the first frame start
         receive_packet_soft_reset <= next_soft_reset;
         if (wr_ctrl) begin
            crc_to_fifo_enable <= i_avs_writedata[CTRL_CRC_BIT];
            packet_source_select <= i_avs_writedata[CTRL_SRC_BIT];
            packet_timeslot_select <= i_avs_writedata[SLOT_W-1:0];
         end
         if (wr_supp) begin
            receive_packet_bit_suppress <= i_avs_writedata[7:0];
         end
      end
   end

   // RULE7 slot applied only by reset
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         applied_slot <= CTRL_RESET_VAL[SLOT_W-1:0];
      end else if (reset_done) begin
         applied_slot <= packet_timeslot_select;
      end
   end

   // ------------------------------------------------------------
   // Source mapping
   // ------------------------------------------------------------
   // RULE5 timeslot or overhead bits
   wire src_ovh = packet_source_select && i_rx.ovh;
   // RULE6 slot code 0 is channel 1
   wire slot_hit = (i_rx.slot == applied_slot);
   // RULE8 RULE9 bit_pos 7 is timeslot bit 8
   wire suppressed = receive_packet_bit_suppress[i_rx.bit_pos];
   wire src_slot = !packet_source_select && slot_hit && !suppressed;
   // RULE10 nothing enters while reset is pending
   wire rx_clear = receive_packet_soft_reset;
   wire bit_in = i_rx.bit_en && (src_ovh || src_slot) && !rx_clear;

   // ------------------------------------------------------------
   // Packet receiver: flag hunt, destuffing, octets, CRC
   // ------------------------------------------------------------
   // The assembler reads the stream seven bits late, so a flag is
   // complete just as its first bit reaches the assembler.
   rpc_rx_state_e state;
   logic [7:0] window;
   logic [3:0] skip;
   logic [2:0] ones;
   logic [7:0] shreg;
   logic [2:0] nbits;
   logic [15:0] crc;
   logic [7:0] held [3];
   logic [1:0] held_cnt;
   logic [1:0] emit_left;
   logic emit_bad;

   wire [7:0] win_next = {window[6:0], i_rx.bit_val};
   wire is_flag = (win_next == FLAG_PAT);
   wire is_abort = (win_next[6:0] == ABORT_PAT);
   wire out_bit = window[6];
   wire in_data = (state == ST_DATA) && (skip == 4'h0);
   wire stuffed = !out_bit && (ones == STUFF_ONES);
   wire take_bit = bit_in && !is_flag && !is_abort && in_data && !stuffed;
   wire octet_done = take_bit && (nbits == 3'h7);
   wire [7:0] octet = {out_bit, shreg[7:1]};
   wire close_ok = bit_in && is_flag && (state == ST_DATA) && (held_cnt == 2'h3);
   wire abort_open = bit_in && is_abort && (state == ST_DATA) && (held_cnt == 2'h3);
   wire frame_bad = (crc != CRC_GOOD) || (nbits != 3'h0);

   // Framing state and raw window
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= ST_HUNT;
         window <= 8'h00;
         skip <= 4'h0;
      end else if (rx_clear) begin
         state <= ST_HUNT;
         window <= 8'h00;
         skip <= 4'h0;
      end else if (bit_in) begin
         window <= win_next;
         if (is_flag) begin
            state <= ST_DATA;
            skip <= FLAG_SKIP - 4'h1;
         end else if (is_abort) begin
            state <= ST_HUNT;
         end else if (skip != 4'h0) begin
            skip <= skip - 4'h1;
         end
      end
   end

   // Destuffing counter on the delayed stream
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ones <= 3'h0;
      end else if (rx_clear || (bit_in && (is_flag || !in_data))) begin
         ones <= 3'h0;
      end else if (bit_in) begin
         ones <= out_bit ? ones + 3'h1 : 3'h0;
      end
   end

   // Octet assembly, LSB first, with running CRC
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         shreg <= 8'h00;
         nbits <= 3'h0;
         crc <= CRC_INIT;
      end else if (rx_clear || (bit_in && is_flag)) begin
         shreg <= 8'h00;
         nbits <= 3'h0;
         crc <= CRC_INIT;
      end else if (take_bit) begin
         shreg <= octet;
         nbits <= nbits + 3'h1;
         crc <= rpc_crc_next(crc, out_bit);
      end
   end

   // ------------------------------------------------------------
   // Octet pipeline: the last two octets may be the CRC
   // ------------------------------------------------------------
   // Three octets are held back; only when a fourth arrives is the
   // oldest known not to be the last packet octet before the CRC.
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         held_cnt <= 2'h0;
         emit_left <= 2'h0;
         emit_bad <= 1'b0;
      end else if (rx_clear) begin
         held_cnt <= 2'h0;
         emit_left <= 2'h0;
         emit_bad <= 1'b0;
      end else if (bit_in && (is_flag || is_abort)) begin
         held_cnt <= 2'h0;
         // RULE1 CRC octets or not
         if (close_ok) begin
            emit_left <= crc_to_fifo_enable ? EMIT_WITH_CRC : EMIT_NO_CRC;
            emit_bad <= frame_bad;
         end else if (abort_open) begin
            emit_left <= EMIT_NO_CRC;
            emit_bad <= 1'b1;
         end
      end else begin
         if (octet_done && held_cnt != 2'h3) begin
            held_cnt <= held_cnt + 2'h1;
         end
         if (emit_left != 2'h0) begin
            emit_left <= emit_left - 2'h1;
         end
      end
   end

   // Held octets shift on arrival and while a packet end drains
   always_ff @(posedge i_mclk) begin
      if (octet_done) begin
         held[2] <= held[1];
         held[1] <= held[0];
         held[0] <= octet;
      end else if (emit_left != 2'h0) begin
         held[2] <= held[1];
         held[1] <= held[0];
      end
   end

   // FIFO write: oldest held octet, end flags on the last one
   always_comb begin
      push = 1'b0;
      push_oct = '0;
      if (emit_left != 2'h0) begin
         push = 1'b1;
         push_oct.data = held[2];
         push_oct.eop = (emit_left == 2'h1);
         push_oct.bad = (emit_left == 2'h1) && emit_bad;
      end else if (octet_done && held_cnt == 2'h3) begin
         push = 1'b1;
         push_oct.data = held[2];
      end
   end

   // Overflow is sticky until the next soft reset
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         overflow <= 1'b0;
      end else if (push && fifo_full && !rx_clear) begin
         overflow <= 1'b1;
      end else if (reset_done) begin
         overflow <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Receive FIFO
   // ------------------------------------------------------------
   // RULE2 flush on soft reset
   rpc_fifo #(
      .WIDTH(OCT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_arst_n(i_arst_n),
      .i_flush(rx_clear),
      .i_push(push),
      .i_data(push_oct),
      .i_pop(pop),
      .o_data(fifo_rd_bits),
      .o_empty(fifo_empty),
      .o_full(fifo_full),
      .o_level(fifo_level)
   );
endmodule

// *** bench/rpc_receive_packet_control_chk.sv ***
`timescale 1ns/10ps
module rpc_receive_packet_control_chk
   import rpc_pkg::*;
#(
   parameter int FIFO_DEPTH = 64
) (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire rpc_frame_s i_rx,
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest
);
   // ------------------------------------------
   // Shadow of what the host has written
   // ------------------------------------------
   logic [7:0] ctrl_sh;
   logic [7:0] supp_sh;
   logic [1:0] fs_cnt;
   wire logic [7:0] idx = i_avs_address[9:2];
   wire logic rd_take = i_avs_read && o_avs_waitrequest;
   wire logic wr_done = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
   wire logic mapped = idx inside {IDX_CTRL, IDX_SUPP, IDX_DATA, IDX_STAT};
   wire logic rst_req = wr_done && idx == IDX_CTRL && i_avs_writedata[CTRL_RST_BIT];
   // Frame starts since the last soft reset request; 3 means none pending
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_sh <= CTRL_RESET_VAL;
         supp_sh <= SUPP_RESET_VAL;
         fs_cnt <= 2'h3;
      end else begin
         if (wr_done && idx == IDX_CTRL) begin
            ctrl_sh <= i_avs_writedata[7:0];
         end
         if (wr_done && idx == IDX_SUPP) begin
            supp_sh <= i_avs_writedata[7:0];
         end
         if (rst_req) begin
            fs_cnt <= 2'h0;
         end else if (i_rx.frame_start && fs_cnt != 2'h3) begin
            fs_cnt <= fs_cnt + 2'h1;
         end
      end
   end
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_arst_n);
   // ------------------------------------------
   // Bus handshake and register view
   // ------------------------------------------
   chk_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("request not answered next cycle");
   chk_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   chk_no_spurious: assert property (!o_avs_waitrequest |-> $past(i_avs_read || i_avs_write))
      else $error("answer without request");
   chk_data_hold: assert property ($changed(o_avs_readdata) |-> $past(rd_take))
      else $error("read data moved without a read");
   chk_unmapped_zero: assert property (rd_take && !mapped |-> ##1 o_avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   chk_supp_readback: assert property (rd_take && idx == IDX_SUPP
      |-> ##1 o_avs_readdata[7:0] == $past(supp_sh)) else $error("suppress readback");
   chk_ctrl_readback: assert property (rd_take && idx == IDX_CTRL
      |-> ##1 (o_avs_readdata[7:0] & 8'hBF) == ($past(ctrl_sh) & 8'hBF))
      else $error("control readback");
   chk_reset_held: assert property (rd_take && idx == IDX_CTRL && fs_cnt == 2'h0
      && !i_rx.frame_start |-> ##1 o_avs_readdata[CTRL_RST_BIT])
      else $error("soft reset bit dropped early");
   chk_reset_clears: assert property (rd_take && idx == IDX_CTRL && fs_cnt >= 2'h2
      |-> ##1 !o_avs_readdata[CTRL_RST_BIT]) else $error("soft reset bit stuck");
endmodule
bind rpc_receive_packet_control rpc_receive_packet_control_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
   .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_rx(i_rx), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
   .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest));

// *** bench/rpc_line_model.sv ***
`timescale 1ns/10ps
module rpc_line_model
   import rpc_pkg::*;
(
   input wire logic i_mclk,
   output rpc_frame_s o_rx
);
   // ------------------------------------------
   // Received frame stream
   // ------------------------------------------
   logic [2:0] pos = 3'h7;
   initial o_rx = '0;
   // One bit event, then a gap, since bit events must be four cycles apart
   task automatic put(input logic v, input logic [4:0] s, input logic [2:0] p, input logic o);
      @(posedge i_mclk);
      o_rx <= '{1'b0, 1'b1, v, s, p, o};
      @(posedge i_mclk);
      o_rx.bit_en <= 1'b0;
      o_rx.bit_val <= ~v;
      repeat (2) @(posedge i_mclk);
   endtask
   task automatic frame();
      @(posedge i_mclk);
      o_rx.frame_start <= 1'b1;
      @(posedge i_mclk);
      o_rx.frame_start <= 1'b0;
   endtask
   // Decoys carry the wrong value in places the receiver must skip
   task automatic send_bit(input logic b, input logic om, input logic [4:0] s,
                           input logic [7:0] sup);
      if (om) begin
         put(~b, s, pos, 1'b0);
         put(b, ~s, 3'h0, 1'b1);
      end else begin
         put(~b, s + 5'h01, pos, 1'b0);
         while (sup[pos]) begin
            put(~b, s, pos, 1'b0);
            pos = pos - 3'h1;
         end
         put(b, s, pos, 1'b0);
         pos = pos - 3'h1;
      end
   endtask
endmodule

// *** bench/rpc_receive_packet_control_tb_top.sv ***
`timescale 1ns/10ps
module rpc_receive_packet_control_tb_top
   import rpc_pkg::*;
;
   // ------------------------------------------
   // Stimulus state
   // ------------------------------------------
   typedef struct packed {
      logic om;
      logic [4:0] s;
      logic [7:0] m;
      logic crc;
      logic [3:0] n;
   } rpc_row_s;
   rpc_row_s rows[4] = '{'{1'b0, 5'h00, 8'h00, 1'b0, 4'h3}, '{1'b0, 5'h1F, 8'h81, 1'b1, 4'h4},
                        '{1'b1, 5'h05, 8'h00, 1'b1, 4'h3}, '{1'b0, 5'h0A, 8'h5A, 1'b0, 4'h5}};
   logic i_mclk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [9:0] addr = 10'h000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'h0;
   logic [31:0] rdata;
   logic wreq;
   logic [31:0] q;
   logic [15:0] fcs;
   logic [7:0] pk[$];
   rpc_frame_s rx;
   int n_mismatch = 0;
   int total_checks = 0;
   always #25 i_mclk = ~i_mclk;
   rpc_line_model line (.i_mclk(i_mclk), .o_rx(rx));
   rpc_receive_packet_control #(.FIFO_DEPTH(16)) uut (
      .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_rx(rx), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq));
   // ------------------------------------------
   // Shared tasks
   // ------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Request held until waitrequest is seen low; a hung slave ends the run
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] b);
      int n;
      n = 0;
      @(posedge i_mclk);
      rd <= ~w;
      wr <= w;
      addr <= {a, 2'b00};
      wdata <= {24'h000000, d};
      be <= b;
      do begin
         @(posedge i_mclk);
         n++;
         if (n > 20) begin
            n_mismatch++;
            conclude();
         end
      end while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rdr(input logic [7:0] a);
      bus(1'b0, a, 8'h00, 4'hF);
   endtask
   // Builds a packet with an all-ones byte, so stuffing is exercised
   task automatic mk(input int r, input int n);
      logic [15:0] c;
      pk.delete();
      for (int i = 0; i < n; i++) pk.push_back((i == 1) ? 8'hFF : 8'(r * 45 + i * 7 + 3));
      c = 16'hFFFF;
      foreach (pk[i]) for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ pk[i][k]) ? CRC_POLY : 16'h0000);
      fcs = ~c;
   endtask
   // Flag, stuffed octets and check sequence; cl=0 leaves the packet open
   task automatic tx(input logic om, input logic [4:0] s, input logic [7:0] m, input logic cl);
      logic [7:0] f[$];
      int ones;
      f = pk;
      f.push_back(fcs[7:0]);
      f.push_back(fcs[15:8]);
      ones = 0;
      for (int k = 0; k < 8; k++) line.send_bit(FLAG_PAT[k], om, s, m);
      foreach (f[i]) for (int k = 0; k < 8; k++) begin
         line.send_bit(f[i][k], om, s, m);
         ones = f[i][k] ? ones + 1 : 0;
         if (ones == 5) begin
            line.send_bit(1'b0, om, s, m);
            ones = 0;
         end
      end
      if (cl) for (int k = 0; k < 8; k++) line.send_bit(FLAG_PAT[k], om, s, m);
      repeat (6) @(posedge i_mclk);
   endtask
   task automatic rx_pkt(input logic c);
      logic [7:0] e[$];
      e = pk;
      if (c) begin
         e.push_back(fcs[7:0]);
         e.push_back(fcs[15:8]);
      end
      foreach (e[i]) begin
         rdr(IDX_DATA);
         check(q, {21'h0, 1'b0, i == e.size() - 1, 1'b1, e[i]});
      end
   endtask
   // Soft reset applies the timeslot; two frame starts bound its completion
   task automatic srst(input logic [7:0] v);
      wrr(IDX_CTRL, v | 8'h40);
      rdr(IDX_CTRL);
      check(q & 32'h40, 32'h40);
      line.frame();
      line.frame();
      rdr(IDX_CTRL);
      check(q, {24'h000000, v});
   endtask
   // ------------------------------------------
   // Main sequence
   // ------------------------------------------
   initial begin
      repeat (20) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      foreach (rows[r]) begin
         wrr(IDX_SUPP, rows[r].m);
         srst({rows[r].crc, 1'b0, rows[r].om, rows[r].s});
         mk(r, rows[r].n);
         tx(rows[r].om, rows[r].s, rows[r].m, 1'b1);
         rx_pkt(rows[r].crc);
         rdr(IDX_STAT);
         check(q, 32'h1);
      end
      // New timeslot without soft reset: old routing stays in force
      wrr(IDX_SUPP, 8'h00);
      wrr(IDX_CTRL, 8'h03);
      rdr(IDX_CTRL);
      check(q, 32'h3);
      mk(7, 3);
      tx(1'b0, 5'h03, 8'h00, 1'b1);
      rdr(IDX_STAT);
      check(q, 32'h1);
      tx(1'b0, 5'h0A, 8'h00, 1'b1);
      rx_pkt(1'b0);
      // Flush: a stored packet, an open one and traffic during the reset
      srst(8'h03);
      mk(8, 4);
      tx(1'b0, 5'h03, 8'h00, 1'b1);
      tx(1'b0, 5'h03, 8'h00, 1'b0);
      wrr(IDX_CTRL, 8'h43);
      tx(1'b0, 5'h03, 8'h00, 1'b1);
      line.frame();
      rdr(IDX_STAT);
      check(q, 32'h1);
      rdr(IDX_CTRL);
      check(q, 32'h3);
      mk(11, 3);
      tx(1'b0, 5'h03, 8'h00, 1'b1);
      rx_pkt(1'b0);
      // Unmapped place and a write without the low byte lane
      wrr(8'h20, 8'h55);
      rdr(8'h20);
      check(q, 32'h0);
      wrr(IDX_SUPP, 8'h24);
      bus(1'b1, IDX_SUPP, 8'h33, 4'hE);
      rdr(IDX_SUPP);
      check(q, 32'h24);
      // Second reset in mid-run restores the register defaults
      i_arst_n <= 1'b0;
      repeat (3) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      rdr(IDX_CTRL);
      check(q, {24'h000000, CTRL_RESET_VAL});
      rdr(IDX_SUPP);
      check(q, {24'h000000, SUPP_RESET_VAL});
      rdr(IDX_STAT);
      check(q, 32'h1);
      conclude();
   end
endmodule
